// file: sam_pkg.sv
package sam_pkg;
    // ==========================================================
    // Address widths and fixed field positions.
    // ==========================================================
    localparam int unsigned ADDR_W      = 28;
    localparam int unsigned COL_MAX_W   = 11;
    localparam int unsigned ROW_MAX_W   = 13;
    localparam int unsigned BANK_W      = 2;
    localparam int unsigned BSEL_POS    = 0;
    localparam int unsigned COL_LSB     = 1;
    localparam int unsigned COL_BASE_W  = 8;
    localparam int unsigned ROW_BASE_W  = 11;

    // ==========================================================
    // Geometry encodings held in the configuration inputs.
    // ==========================================================
    localparam logic [1:0] ROWS_2K   = 2'h0;
    localparam logic [1:0] ROWS_4K   = 2'h1;
    localparam logic [1:0] ROWS_8K   = 2'h2;
    localparam logic [1:0] COLS_256  = 2'h0;
    localparam logic [1:0] COLS_512  = 2'h1;
    localparam logic [1:0] COLS_1024 = 2'h2;
    localparam logic [1:0] COLS_2048 = 2'h3;
    localparam logic       BANKS_TWO = 1'h0;

    // ==========================================================
    // Values after reset.
    // ==========================================================
    localparam logic [ROW_MAX_W-1:0] ROW_RST  = 13'h0000;
    localparam logic [COL_MAX_W-1:0] COL_RST  = 11'h000;
    localparam logic [BANK_W-1:0]    BANK_RST = 2'h0;
    localparam logic [1:0]           SYNC_RST = 2'h0;
endpackage

// file: sam_addr_map.sv
`timescale 1ns/1ps
// What this block does
// - Address bit zero selects halfword byte lane.
// - Column bits sit just above byte select.
// - 2K rows: 11-bit row, bank above.
// - 4K rows: 12-bit row, bank one higher.
// - 8K rows: 13-bit row, bank above.
// - Configuration chooses row and bank field positions.
// - One interrupt request line to system.
// - Refresh error sets flag, read clears.
module sam_addr_map #(
    parameter int unsigned ADDR_W = sam_pkg::ADDR_W
) (
    input  wire logic              i_mclk,
    input  wire logic              i_rst_b,
    input  wire logic              i_ce,
    input  wire logic              i_req,
    input  wire logic [ADDR_W-1:0] i_addr,
    input  wire logic [1:0]        i_cfg_rows,
    input  wire logic [1:0]        i_cfg_cols,
    input  wire logic              i_cfg_banks,
    input  wire logic              i_refresh_missed,
    input  wire logic              i_isr_read,
    output logic                   o_map_valid,
    output logic                   o_byte_sel,
    output logic [12:0]            o_row,
    output logic [10:0]            o_col,
    output logic [1:0]             o_bank,
    output logic                   o_refresh_error_flag,
    output logic                   o_irq
);
    import sam_pkg::*;

    // ==========================================================
    // State and helpers.
    // ==========================================================
    typedef struct packed {
        logic                 valid;
        logic                 bsel;
        logic [ROW_MAX_W-1:0] row;
        logic [COL_MAX_W-1:0] col;
        logic [BANK_W-1:0]    bank;
        logic                 err;
    } sam_state_s;

    sam_state_s cur;
    sam_state_s next_cur;
    logic [1:0] rst_sync;
    logic       rst_n;
    logic [3:0] col_w;
    logic [3:0] row_w;
    logic [4:0] row_lsb;
    logic [4:0] bank_lsb;

    // Extracts a field of up to 13 bits starting at lsb.
    function automatic logic [12:0] take_field(
        input logic [ADDR_W-1:0] addr,
        input logic [4:0]        lsb,
        input logic [3:0]        width
    );
        logic [ADDR_W-1:0] shifted;
        logic [12:0]       mask;
        shifted = addr >> lsb;
        mask    = 13'((14'h0001 << width) - 14'h0001);
        return shifted[12:0] & mask;
    endfunction

    // ==========================================================
    // Reset release through two flip-flops.
    // ==========================================================
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rst_sync <= SYNC_RST;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    // Field widths and positions follow the configured geometry.
    always_comb begin
        col_w = 4'(COL_BASE_W) + {2'h0, i_cfg_cols};
        case (i_cfg_rows)
            ROWS_4K: row_w = 4'(ROW_BASE_W + 1);
            ROWS_8K: row_w = 4'(ROW_BASE_W + 2);
            default: row_w = 4'(ROW_BASE_W);
        endcase
        row_lsb  = 5'(COL_LSB) + {1'b0, col_w};
        bank_lsb = row_lsb + {1'b0, row_w};
    end

    // ==========================================================
    // Next state: address split and refresh error flag.
    // ==========================================================
    always_comb begin
        next_cur       = cur;
        next_cur.valid = 1'b0;
        if (i_req) begin
            next_cur.valid = 1'b1;
            next_cur.bsel  = i_addr[BSEL_POS];
            next_cur.col   = 11'(take_field(i_addr, 5'(COL_LSB), col_w));
            next_cur.row   = take_field(i_addr, row_lsb, row_w);
            // Bits above the bank field never reach the outputs.
            next_cur.bank  = 2'(take_field(i_addr, bank_lsb,
                                           4'(BANK_W)));
            if (i_cfg_banks == BANKS_TWO) begin
                next_cur.bank[1] = 1'b0;
            end
        end
        // A miss in the same cycle as the status read keeps the flag.
        if (i_refresh_missed) begin
            next_cur.err = 1'b1;
        end else if (i_isr_read) begin
            next_cur.err = 1'b0;
        end
    end

    // Registers the whole state; clock enable freezes it.
    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            cur <= '{valid: 1'b0, bsel: 1'b0, row: ROW_RST,
                     col: COL_RST, bank: BANK_RST, err: 1'b0};
        end else if (i_ce) begin
            cur <= next_cur;
        end
    end

    // ==========================================================
    // Outputs.
    // ==========================================================
    assign o_map_valid          = cur.valid;
    assign o_byte_sel           = cur.bsel;
    assign o_row                = cur.row;
    assign o_col                = cur.col;
    assign o_bank               = cur.bank;
    assign o_refresh_error_flag = cur.err;
    assign o_irq                = cur.err;

    // ==========================================================
    // Checks on the mapping and the error flag.
    // ==========================================================
    byte_lane_a: assert property (@(posedge i_mclk) disable iff (!rst_n)
        $past(i_ce && i_req) |-> o_byte_sel == $past(i_addr[0]))
        else $error("Byte select does not follow address bit zero.");

    col_width_a: assert property (@(posedge i_mclk) disable iff (!rst_n)
        $past(i_ce && i_req && i_cfg_cols == COLS_512)
        |-> o_col == {2'h0, $past(i_addr[9:1])})
        else $error("Column field wrong for 512 columns.");

    rows_2k_a: assert property (@(posedge i_mclk) disable iff (!rst_n)
        $past(i_ce && i_req && i_cfg_rows == ROWS_2K
              && i_cfg_cols == COLS_256 && i_cfg_banks)
        |-> o_row == {2'h0, $past(i_addr[19:9])}
            && o_bank == $past(i_addr[21:20]))
        else $error("Row or bank wrong for 2K rows.");

    rows_4k_a: assert property (@(posedge i_mclk) disable iff (!rst_n)
        $past(i_ce && i_req && i_cfg_rows == ROWS_4K
              && i_cfg_cols == COLS_256 && i_cfg_banks)
        |-> o_row == {1'b0, $past(i_addr[20:9])}
            && o_bank == $past(i_addr[22:21]))
        else $error("Row or bank wrong for 4K rows.");

    rows_8k_a: assert property (@(posedge i_mclk) disable iff (!rst_n)
        $past(i_ce && i_req && i_cfg_rows == ROWS_8K
              && i_cfg_cols == COLS_2048 && i_cfg_banks)
        |-> o_row == $past(i_addr[24:12]) && o_col == $past(i_addr[11:1])
            && o_bank == $past(i_addr[26:25]))
        else $error("Fields wrong for 8K rows and 2048 columns.");

    map_strobe_a: assert property (@(posedge i_mclk) disable iff (!rst_n)
        $past(i_ce) |-> o_map_valid == $past(i_req))
        else $error("Map strobe does not follow the request.");

    irq_raise_a: assert property (@(posedge i_mclk) disable iff (!rst_n)
        $past(i_ce && i_refresh_missed)
        |-> o_irq ##1 (o_irq || $past(i_isr_read)))
        else $error("Interrupt not raised after a refresh miss.");

    flag_clear_a: assert property (@(posedge i_mclk) disable iff (!rst_n)
        $past(i_ce && i_isr_read && !i_refresh_missed)
        |-> !o_refresh_error_flag)
        else $error("Status read did not clear the refresh error.");

    upper_ignore_a: assert property (@(posedge i_mclk)
        disable iff (!rst_n)
        $past(i_ce && i_req && i_cfg_banks == BANKS_TWO) |-> !o_bank[1])
        else $error("Bank bit one set with two banks.");

    // The smallest column count leaves the upper column bits at zero.
    cols_256_a: assert property (@(posedge i_mclk)
        disable iff (!rst_n)
        $past(i_ce && i_req && i_cfg_cols == COLS_256)
        |-> o_col == {3'h0, $past(i_addr[8:1])})
        else $error("Column field wrong for 256 columns.");

    // Ten column bits sit right above the byte select.
    cols_1024_a: assert property (@(posedge i_mclk)
        disable iff (!rst_n)
        $past(i_ce && i_req && i_cfg_cols == COLS_1024)
        |-> o_col == {1'b0, $past(i_addr[10:1])})
        else $error("Column field wrong for 1024 columns.");

    // The spare row code is decoded as the 2K geometry.
    rows_spare_a: assert property (@(posedge i_mclk)
        disable iff (!rst_n)
        $past(i_ce && i_req && i_cfg_rows == 2'h3
              && i_cfg_cols == COLS_256 && i_cfg_banks)
        |-> o_row == {2'h0, $past(i_addr[19:9])}
            && o_bank == $past(i_addr[21:20]))
        else $error("Row or bank wrong for the spare row code.");

    // With 2K rows and 2048 columns the bank lands on bits 24 and 23.
    rows_wide_a: assert property (@(posedge i_mclk)
        disable iff (!rst_n)
        $past(i_ce && i_req && i_cfg_rows == ROWS_2K
              && i_cfg_cols == COLS_2048 && i_cfg_banks)
        |-> o_col == $past(i_addr[11:1])
            && o_row == {2'h0, $past(i_addr[22:12])}
            && o_bank == $past(i_addr[24:23]))
        else $error("Fields wrong for 2K rows and 2048 columns.");

    // Fields keep the last split until a new request is taken.
    fields_hold_a: assert property (@(posedge i_mclk)
        disable iff (!rst_n)
        $past(i_ce && !i_req)
        |-> $stable({o_byte_sel, o_row, o_col, o_bank}))
        else $error("Address fields moved without a request.");

    // A missed refresh always leaves the flag set, even against a read.
    flag_set_a: assert property (@(posedge i_mclk)
        disable iff (!rst_n)
        $past(i_ce && i_refresh_missed) |-> o_refresh_error_flag)
        else $error("Refresh error flag not set after a miss.");

    // The flag is sticky until the status register is read.
    flag_keep_a: assert property (@(posedge i_mclk)
        disable iff (!rst_n)
        $past(i_ce && !i_isr_read && o_refresh_error_flag)
        |-> o_refresh_error_flag)
        else $error("Refresh error flag dropped without a status read.");
endmodule

// file: sam_sdram_model.sv
`timescale 1ns/1ps
// ==========================================================
// Memory side: latches lane, column, row and bank per valid.
// ==========================================================
module sam_sdram_model (
    input  wire logic        i_mclk,
    input  wire logic        i_map_valid,
    input  wire logic        i_byte_sel,
    input  wire logic [12:0] i_row,
    input  wire logic [10:0] i_col,
    input  wire logic [1:0]  i_bank,
    output logic [26:0]      o_seen
);
    // Capture the presented address whenever the mapper flags it.
    always_ff @(posedge i_mclk) begin
        if (i_map_valid === 1'b1) begin
            o_seen <= {i_bank, i_row, i_col, i_byte_sel};
        end
    end
endmodule

// file: sam_addr_map_bench.sv
`timescale 1ns/1ps
// ==========================================================
// Self-checking bench for the address mapper.
// ==========================================================
module sam_addr_map_bench;
    import sam_pkg::*;
    logic        i_mclk, i_rst_b, i_ce, i_req, i_cfg_banks;
    logic        i_refresh_missed, i_isr_read;
    logic [27:0] i_addr;
    logic [1:0]  i_cfg_rows, i_cfg_cols, o_bank;
    logic        o_map_valid, o_byte_sel, o_refresh_error_flag, o_irq;
    logic [12:0] o_row;
    logic [10:0] o_col;
    logic [26:0] seen, exp_all;
    int          n_fail = 0;
    int          total_checks = 0;

    sam_addr_map dut_u (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_ce(i_ce),
        .i_req(i_req), .i_addr(i_addr), .i_cfg_rows(i_cfg_rows),
        .i_cfg_cols(i_cfg_cols), .i_cfg_banks(i_cfg_banks),
        .i_refresh_missed(i_refresh_missed), .i_isr_read(i_isr_read),
        .o_map_valid(o_map_valid), .o_byte_sel(o_byte_sel), .o_row(o_row),
        .o_col(o_col), .o_bank(o_bank), .o_irq(o_irq),
        .o_refresh_error_flag(o_refresh_error_flag));
    sam_sdram_model mem_u (.i_mclk(i_mclk), .i_map_valid(o_map_valid),
        .i_byte_sel(o_byte_sel), .i_row(o_row), .i_col(o_col),
        .i_bank(o_bank), .o_seen(seen));

    // Clock of 100 ns period.
    initial begin
        i_mclk = 1'b0;
        forever #50 i_mclk = ~i_mclk;
    end

    task automatic chk(input string nm, input logic [27:0] e,
                       input logic [27:0] g);
        total_checks++;
        if (g !== e) begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic step;
        @(posedge i_mclk);
        #1;
    endtask

    // Requests one split and compares it with the field layout.
    task automatic do_map(input logic [1:0] r, input logic [1:0] c,
                          input logic b, input logic [27:0] a);
        int          cw;
        int          rw;
        logic [27:0] s;
        logic [12:0] er;
        logic [10:0] ec;
        logic [1:0]  eb;
        cw = 8 + c;
        rw = (r == ROWS_4K) ? 12 : (r == ROWS_8K) ? 13 : 11;
        s = a >> 1;
        ec = 11'(s & ((28'h1 << cw) - 28'h1));
        s = s >> cw;
        er = 13'(s & ((28'h1 << rw) - 28'h1));
        eb = 2'((s >> rw) & 28'h3);
        if (b == 1'b0) eb[1] = 1'b0;
        {i_cfg_rows, i_cfg_cols, i_cfg_banks} = {r, c, b};
        {i_addr, i_req} = {a, 1'b1};
        step;
        chk("valid", 27'h1, 27'(o_map_valid));
        chk("byte_sel", 27'(a[0]), 27'(o_byte_sel));
        chk("col", 27'(ec), 27'(o_col));
        chk("row", 27'(er), 27'(o_row));
        chk("bank", 27'(eb), 27'(o_bank));
        exp_all = {eb, er, ec, a[0]};
    endtask

    // Every geometry back to back, with high address bits set.
    task automatic test_map;
        for (int k = 0; k < 32; k++) begin
            do_map(2'(k >> 3), 2'(k >> 1), k[0],
                   28'(28'hFFFFFFF ^ (k * 28'h1357)));
            do_map(2'(k >> 3), 2'(k >> 1), k[0], 28'(28'hA5A5A5B + k));
        end
        i_req = 1'b0;
        step;
        chk("valid_drop", 27'h0, 27'(o_map_valid));
        chk("hold", exp_all, {o_bank, o_row, o_col, o_byte_sel});
        chk("memory", exp_all, seen);
        do_map(ROWS_8K, COLS_2048, 1'b1, 28'h0C0FFEE);
        {i_ce, i_req, i_addr} = {1'b0, 1'b1, 28'h1234567};
        step;
        chk("freeze", {exp_all, 1'b1},
            {o_bank, o_row, o_col, o_byte_sel, o_map_valid});
        {i_ce, i_req} = 2'b10;
        step;
        chk("thaw", 27'h0, 27'(o_map_valid));
        // Controller idle first, then its clock gated: nothing moves.
        i_ce = 1'b0;
        step;
        chk("gated", 27'h0, 27'(o_map_valid));
        chk("gated_hold", {1'b0, exp_all},
            {1'b0, o_bank, o_row, o_col, o_byte_sel});
        i_ce = 1'b1;
    endtask

    // Refresh flag set, clear, and set winning over clear.
    task automatic test_refresh;
        logic [2:0] seq [5];
        seq = '{3'b101, 3'b001, 3'b010, 3'b111, 3'b010};
        foreach (seq[i]) begin
            {i_refresh_missed, i_isr_read} = seq[i][2:1];
            step;
            chk("flag", 27'(seq[i][0]), 27'(o_refresh_error_flag));
            chk("irq", 27'(seq[i][0]), 27'(o_irq));
        end
        i_isr_read = 1'b0;
    endtask

    // Reset in mid-run clears every output.
    task automatic test_reset;
        i_refresh_missed = 1'b1;
        step;
        i_refresh_missed = 1'b0;
        i_rst_b = 1'b0;
        #1;
        chk("reset", 27'h0, {o_map_valid, o_refresh_error_flag, o_irq, o_row});
        chk("reset_fields", 27'h0, {o_bank, o_col, o_byte_sel});
        step;
        i_rst_b = 1'b1;
        repeat (3) step;
        chk("released", 27'h0, {o_map_valid, o_refresh_error_flag, o_irq});
    endtask

    task automatic complete_run;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Main sequence.
    initial begin
        {i_rst_b, i_ce, i_req, i_cfg_banks, i_refresh_missed} = 5'h0;
        {i_isr_read, i_addr, i_cfg_rows, i_cfg_cols} = 33'h0;
        repeat (2) step;
        i_rst_b = 1'b1;
        repeat (3) step;
        i_ce = 1'b1;
        test_map;
        test_refresh;
        test_reset;
        do_map(ROWS_4K, COLS_512, 1'b1, 28'hFEDCBA9);
        complete_run;
    end

    // Watchdog against a hang.
    initial begin
        #500000;
        n_fail++;
        complete_run;
    end
endmodule
